/* hw/apm_defs.svh */
// apm_defs.svh: offsets, field positions, masks and reset values for the
// fixed event register block.
// assumes: included by bare name from the design files under hw/.
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH

// host offsets inside the eight-byte window
`define APM_WINDOW_BYTES 8
`define APM_OFF_STS_LO 3'h0
`define APM_OFF_STS_HI 3'h1
`define APM_OFF_EN_LO 3'h2
`define APM_OFF_EN_HI 3'h3
`define APM_OFF_CTL_LO 3'h4
`define APM_OFF_CTL_HI 3'h5
`define APM_OFF_RSVD_A 3'h6
`define APM_OFF_RSVD_B 3'h7

// configuration register indices
`define APM_CFG_ACTIVATE 8'h30
`define APM_CFG_BASE_HI 8'h60
`define APM_CFG_BASE_LO 8'h61

// controller-side register selects
`define APM_MC_STATUS 2'h0
`define APM_MC_ENABLE 2'h1
`define APM_MC_CONTROL 2'h2

// implemented bits
`define APM_STS_MASK 8'h8f
`define APM_EN_MASK 8'h07
`define APM_CTL_MASK 8'h3e
`define APM_CTL_MC_MASK 8'h20
`define APM_ACT_MASK 8'h01
`define APM_BASE_HI_MASK 8'h0f
`define APM_BASE_LO_MASK 8'hf8

// field positions
`define APM_BIT_PWRBTN 0
`define APM_BIT_SLPBTN 1
`define APM_BIT_ALARM 2
`define APM_BIT_OVERRIDE 3
`define APM_BIT_WAKE 7
`define APM_BIT_OVR_EN 1
`define APM_SLP_TYPE_LSB 2
`define APM_SLP_TYPE_MSB 4
`define APM_BIT_SLEEP_ENABLE 5

// reset values
`define APM_RESET_BYTE 8'h00

`endif

/* hw/apm_pkg.sv */
// apm_pkg.sv: types shared by the fixed event register block.
// assumes: apm_defs.svh supplies the numeric constants.
package apm_pkg;

    typedef logic [7:0] apm_byte_t;

    // one-hot select of the eight host offsets
    typedef enum logic [7:0] {
        APM_SEL_NONE = 8'h00,
        APM_SEL_STS_LO = 8'h01,
        APM_SEL_STS_HI = 8'h02,
        APM_SEL_EN_LO = 8'h04,
        APM_SEL_EN_HI = 8'h08,
        APM_SEL_CTL_LO = 8'h10,
        APM_SEL_CTL_HI = 8'h20,
        APM_SEL_RSVD_A = 8'h40,
        APM_SEL_RSVD_B = 8'h80
    } apm_sel_t;

endpackage : apm_pkg

/* hw/apm_decode.sv */
// apm_decode.sv: host I/O window decode for the fixed event block.
// assumes: base bytes arrive already masked to their implemented bits.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"

module apm_decode (
    // configuration
    input wire logic activate,
    input wire logic [7:0] base_high,
    input wire logic [7:0] base_low,
    // host address
    input wire logic [15:0] addr,
    // result
    output logic hit,
    output logic [2:0] offset
);

    wire [15:0] base_addr = {4'h0, base_high[3:0], base_low[7:3], 3'h0};
    wire same_window = (addr[15:3] == base_addr[15:3]);

    assign hit = activate & same_window;
    assign offset = addr[2:0];

endmodule : apm_decode
`default_nettype wire

/* hw/apm_status.sv */
// apm_status.sv: status byte set by events and the controller, cleared
// by host write-one.
// assumes: all inputs synchronous to clock; reset is the standby-plane POR.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"

module apm_status #(
    parameter logic [7:0] MASK = `APM_STS_MASK
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // sources
    input wire logic [7:0] event_set,
    input wire logic mc_write,
    input wire logic [7:0] mc_wdata,
    input wire logic [7:0] host_clear,
    // state
    output logic [7:0] status
);

    logic [7:0] status_reg;
    logic [7:0] status_next;

    // controller write is direct; events win over any clear
    assign status_next = ((mc_write ? mc_wdata : (status_reg & ~host_clear))
                          | event_set) & MASK;
    assign status = status_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= `APM_RESET_BYTE;
        end else begin
            status_reg <= status_next;
        end
    end

endmodule : apm_status
`default_nettype wire

/* hw/apm_block.sv */
// apm_block.sv: fixed event register block with host I/O window,
// configuration registers, controller access and the interrupt pin.
// assumes: single clock; host, configuration and controller strobes are
// one-cycle, synchronous; RESET_N is the standby-plane power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"

// Function
// - decode eight host bytes from block base
// - decode only while activate bit is set
// - base A11..A8 and A7..A3 from config
// - status, enable, control, reserved offset layout
// - status set only by events or controller
// - host write-one clears; zero ignored; POR clears
// - status sets regardless; interrupt needs enable
// - enable bits share status bit positions
// - controller writes status, reads enables only
// - override status bit, enable at control bit1
// - power button status, enable gate interrupt
// - sleep button status, enable gate interrupt
// - alarm status set by controller, host enables
// - enabled alarm raises wake request output
// - low interrupt pin, also controller sci status
// - wake status, sleep type, sleep enable kept
// - event block registers reset only by standby POR
// - config registers cleared by config resets
// - host writes to high registers interrupt controller
// - status bit map, bits 4..6 read zero
module apm_block (
    // clock and standby-plane reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // hard, soft or main-plane reset of configuration
    input wire logic CFG_RESET_N,
    // host I/O cycles
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic IO_HIT,
    output logic [7:0] IO_RDATA,
    // configuration space
    input wire logic [7:0] CFG_INDEX,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA,
    // embedded controller
    input wire logic [1:0] MC_SEL,
    input wire logic MC_WR,
    input wire logic MC_RD,
    input wire logic [7:0] MC_WDATA,
    output logic [7:0] MC_RDATA,
    output logic MC_IRQ,
    input wire logic CONTROLLER_SCI_STATUS,
    // hardware events
    input wire logic [7:0] EVENT_SET,
    // system side
    output logic SCI_OUT_N,
    output logic WAKE_REQ,
    output logic SLEEP_ENABLE,
    output logic [2:0] SLEEP_TYPE
);

    // configuration registers
    logic [7:0] activate_reg;
    logic [7:0] base_high_reg;
    logic [7:0] base_low_reg;
    // event block registers
    logic [7:0] enable_high_reg;
    logic [7:0] control_high_reg;
    logic [7:0] control_high_next;
    logic [7:0] status_high;
    // output flops
    logic [7:0] io_rdata_reg;
    logic [7:0] cfg_rdata_reg;
    logic [7:0] mc_rdata_reg;
    logic mc_irq_reg;

    wire cfg_reset_n = RESET_N & CFG_RESET_N;

    // host decode
    wire io_hit;
    wire [2:0] io_offset;

    apm_decode u_decode (
        .activate(activate_reg[0]),
        .base_high(base_high_reg),
        .base_low(base_low_reg),
        .addr(IO_ADDR),
        .hit(io_hit),
        .offset(io_offset)
    );

    function automatic apm_pkg::apm_sel_t offset_sel(input logic [2:0] off);
        offset_sel = apm_pkg::apm_sel_t'(8'h01 << off);
    endfunction : offset_sel

    wire apm_pkg::apm_sel_t io_sel = io_hit ? offset_sel(io_offset)
                                            : apm_pkg::APM_SEL_NONE;
    wire io_access = IO_WR | IO_RD;
    wire host_wr_sts = IO_WR & (io_sel == apm_pkg::APM_SEL_STS_HI);
    wire host_wr_en = IO_WR & (io_sel == apm_pkg::APM_SEL_EN_HI);
    wire host_wr_ctl = IO_WR & (io_sel == apm_pkg::APM_SEL_CTL_HI);
    wire host_wr_high = host_wr_sts | host_wr_en | host_wr_ctl;

    // controller decode
    wire mc_wr_sts = MC_WR & (MC_SEL == `APM_MC_STATUS);
    wire mc_wr_ctl = MC_WR & (MC_SEL == `APM_MC_CONTROL);

    // configuration decode
    wire cfg_wr_act = CFG_WR & (CFG_INDEX == `APM_CFG_ACTIVATE);
    wire cfg_wr_bhi = CFG_WR & (CFG_INDEX == `APM_CFG_BASE_HI);
    wire cfg_wr_blo = CFG_WR & (CFG_INDEX == `APM_CFG_BASE_LO);

    // status: host write-one clear, controller direct, events set
    wire [7:0] host_clear = host_wr_sts ? IO_WDATA : 8'h00;

    apm_status #(
        .MASK(`APM_STS_MASK)
    ) u_status (
        .clock(CLOCK),
        .reset_n(RESET_N),
        .event_set(EVENT_SET),
        .mc_write(mc_wr_sts),
        .mc_wdata(MC_WDATA),
        .host_clear(host_clear),
        .status(status_high)
    );

    // controller may only touch the sleep enable in control
    wire [7:0] ctl_host_val = host_wr_ctl
        ? (IO_WDATA & `APM_CTL_MASK) : control_high_reg;
    assign control_high_next = mc_wr_ctl
        ? ((ctl_host_val & ~`APM_CTL_MC_MASK)
           | (MC_WDATA & `APM_CTL_MC_MASK))
        : ctl_host_val;

    // interrupt terms, enables line up with status bits
    wire [7:0] sts_en_match = status_high & enable_high_reg;
    wire override_pending = status_high[`APM_BIT_OVERRIDE]
        & control_high_reg[`APM_BIT_OVR_EN];
    wire sci_active = (|sts_en_match) | override_pending
        | CONTROLLER_SCI_STATUS;

    // host read mux; unimplemented offsets read zero
    wire [7:0] io_read_value =
        (io_sel == apm_pkg::APM_SEL_STS_HI) ? status_high :
        (io_sel == apm_pkg::APM_SEL_EN_HI) ? enable_high_reg :
        (io_sel == apm_pkg::APM_SEL_CTL_HI) ? control_high_reg :
        8'h00;

    wire [7:0] cfg_read_value =
        (CFG_INDEX == `APM_CFG_ACTIVATE) ? activate_reg :
        (CFG_INDEX == `APM_CFG_BASE_HI) ? base_high_reg :
        (CFG_INDEX == `APM_CFG_BASE_LO) ? base_low_reg :
        8'h00;

    wire [7:0] mc_read_value =
        (MC_SEL == `APM_MC_STATUS) ? status_high :
        (MC_SEL == `APM_MC_ENABLE) ? enable_high_reg :
        (MC_SEL == `APM_MC_CONTROL) ? control_high_reg :
        8'h00;

    // configuration registers reset on every reset kind
    always_ff @(posedge CLOCK or negedge cfg_reset_n) begin
        if (!cfg_reset_n) begin
            activate_reg <= `APM_RESET_BYTE;
            base_high_reg <= `APM_RESET_BYTE;
            base_low_reg <= `APM_RESET_BYTE;
        end else begin
            if (cfg_wr_act) begin
                activate_reg <= CFG_WDATA & `APM_ACT_MASK;
            end
            if (cfg_wr_bhi) begin
                base_high_reg <= CFG_WDATA & `APM_BASE_HI_MASK;
            end
            // low three bits forced zero keeps the window aligned
            if (cfg_wr_blo) begin
                base_low_reg <= CFG_WDATA & `APM_BASE_LO_MASK;
            end
        end
    end

    // standby-plane registers survive main power loss
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_high_reg <= `APM_RESET_BYTE;
            control_high_reg <= `APM_RESET_BYTE;
        end else begin
            if (host_wr_en) begin
                enable_high_reg <= IO_WDATA & `APM_EN_MASK;
            end
            control_high_reg <= control_high_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            io_rdata_reg <= `APM_RESET_BYTE;
            cfg_rdata_reg <= `APM_RESET_BYTE;
            mc_rdata_reg <= `APM_RESET_BYTE;
            mc_irq_reg <= 1'b0;
        end else begin
            if (IO_RD) begin
                io_rdata_reg <= io_read_value;
            end
            if (CFG_RD) begin
                cfg_rdata_reg <= cfg_read_value;
            end
            if (MC_RD) begin
                mc_rdata_reg <= mc_read_value;
            end
            mc_irq_reg <= host_wr_high;
        end
    end

    assign IO_HIT = io_hit & io_access;
    assign IO_RDATA = io_rdata_reg;
    assign CFG_RDATA = cfg_rdata_reg;
    assign MC_RDATA = mc_rdata_reg;
    assign MC_IRQ = mc_irq_reg;
    // pin is a level; the host clears the cause, not the pin
    assign SCI_OUT_N = ~sci_active;
    // alarm wakes only once the host has enabled it
    assign WAKE_REQ = status_high[`APM_BIT_ALARM]
        & enable_high_reg[`APM_BIT_ALARM];
    assign SLEEP_ENABLE = control_high_reg[`APM_BIT_SLEEP_ENABLE];
    assign SLEEP_TYPE =
        control_high_reg[`APM_SLP_TYPE_MSB:`APM_SLP_TYPE_LSB];

    // checks
    wire [15:0] chk_base = {4'h0, base_high_reg[3:0], base_low_reg[7:3],
                            3'h0};
    wire chk_in_window = (IO_ADDR >= chk_base)
        && ({1'b0, IO_ADDR} < ({1'b0, chk_base} + 17'd8));

    a_decode_window: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        io_access |-> (IO_HIT == (activate_reg[0] && chk_in_window)))
        else $error("host window decode mismatch");

    a_inactive_no_hit: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        !activate_reg[0] |-> !IO_HIT)
        else $error("decode while block inactive");

    a_base_fields_zero: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (base_high_reg[7:4] == 4'h0) && (base_low_reg[2:0] == 3'h0))
        else $error("base address unused bits not zero");

    a_reserved_reads_zero: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (IO_RD && IO_HIT && (io_offset != `APM_OFF_STS_HI)
         && (io_offset != `APM_OFF_EN_HI)
         && (io_offset != `APM_OFF_CTL_HI))
        |=> (IO_RDATA == 8'h00))
        else $error("reserved offset returned data");

    a_status_read_back: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (IO_RD && IO_HIT && (io_offset == `APM_OFF_STS_HI))
        |=> (IO_RDATA == $past(status_high)))
        else $error("status read at offset one wrong");

    a_host_clear_one: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (host_wr_sts && !MC_WR && (EVENT_SET == 8'h00))
        |=> (status_high == ($past(status_high) & ~$past(IO_WDATA))))
        else $error("host write-one clear wrong");

    a_host_no_set: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (!mc_wr_sts && (EVENT_SET == 8'h00))
        |=> ((status_high & ~$past(status_high)) == 8'h00))
        else $error("status bit set without a source");

    a_status_map: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (status_high[6:4] == 3'h0) && (enable_high_reg[7:3] == 5'h00))
        else $error("unimplemented status or enable bit set");

    a_mc_enable_ro: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (MC_WR && (MC_SEL == `APM_MC_ENABLE) && !host_wr_en)
        |=> $stable(enable_high_reg))
        else $error("controller changed an enable");

    a_sci_level: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        SCI_OUT_N == !((|(status_high & enable_high_reg))
            || (status_high[3] && control_high_reg[1])
            || CONTROLLER_SCI_STATUS))
        else $error("interrupt pin level wrong");

    a_status_without_sci: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        ((enable_high_reg == 8'h00) && !control_high_reg[1]
         && !CONTROLLER_SCI_STATUS) |-> SCI_OUT_N)
        else $error("interrupt without an enable");

    a_mc_irq_pulse: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        host_wr_high |=> MC_IRQ ##1 (MC_IRQ == $past(host_wr_high)))
        else $error("controller interrupt not one per write");

    a_wake_alarm: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        WAKE_REQ == (status_high[2] && enable_high_reg[2]))
        else $error("alarm wake request wrong");

    a_ctl_mc_bit5: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (mc_wr_ctl && !host_wr_ctl)
        |=> (control_high_reg[4:1] == $past(control_high_reg[4:1]))
            && (SLEEP_ENABLE == $past(MC_WDATA[5])))
        else $error("controller control write wrong");

    a_event_sets_status: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (EVENT_SET != 8'h00)
        |=> ((status_high & $past(EVENT_SET) & `APM_STS_MASK)
             == ($past(EVENT_SET) & `APM_STS_MASK)))
        else $error("event did not set its status bit");

    a_mc_status_write: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (mc_wr_sts && (EVENT_SET == 8'h00))
        |=> (status_high == ($past(MC_WDATA) & `APM_STS_MASK)))
        else $error("controller status write not stored");

    a_mc_irq_quiet: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        !host_wr_high |=> !MC_IRQ)
        else $error("controller interrupt without a host write");

    a_cfg_reset_clear: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        !CFG_RESET_N |-> ((activate_reg == 8'h00)
            && (base_high_reg == 8'h00) && (base_low_reg == 8'h00)))
        else $error("configuration not cleared by its reset");

    a_unhit_read_zero: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (IO_RD && !IO_HIT) |=> (IO_RDATA == 8'h00))
        else $error("unclaimed read returned data");

endmodule : apm_block
`default_nettype wire

/* sim/apm_mc_model.sv */
// apm_mc_model.sv: behavioural embedded controller beside the event block.
// assumes: shares the block clock; changes its strobes at falling edges.
`timescale 1ns/1ps
`default_nettype none

module apm_mc_model (
    // clock
    input wire logic clock,
    // controller port of the block
    output logic [1:0] mc_sel,
    output logic mc_wr,
    output logic mc_rd,
    output logic [7:0] mc_wdata,
    input wire logic [7:0] mc_rdata,
    output logic sci_status
);
    initial begin
        mc_sel = 2'h3;
        mc_wr = 1'b0;
        mc_rd = 1'b0;
        mc_wdata = 8'h00;
        sci_status = 1'b0;
    end

    // status writes stand in for button and alarm events
    task automatic put(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clock);
        mc_sel = sel;
        mc_wdata = d;
        mc_wr = 1'b1;
        @(negedge clock);
        mc_wr = 1'b0;
        mc_sel = 2'h3;
        // released data must not look held
        mc_wdata = ~d;
    endtask : put

    task automatic get(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clock);
        mc_sel = sel;
        mc_rd = 1'b1;
        @(negedge clock);
        mc_rd = 1'b0;
        mc_sel = 2'h3;
        d = mc_rdata;
    endtask : get

    task automatic sci(input logic v);
        @(negedge clock);
        sci_status = v;
        @(negedge clock);
    endtask : sci
endmodule : apm_mc_model

`default_nettype wire

/* sim/tb_top.sv */
// tb_top.sv: self-checking bench for the fixed event register block.
// assumes: apm_mc_model plays the controller; host side driven here.
`timescale 1ns/1ps
`default_nettype none
`include "apm_defs.svh"

module tb_top;
    logic CLOCK, RESET_N, CFG_RESET_N, IO_WR, IO_RD, IO_HIT, CFG_WR, CFG_RD;
    logic [15:0] IO_ADDR, base;
    logic [7:0] IO_WDATA, IO_RDATA, CFG_INDEX, CFG_WDATA, CFG_RDATA;
    logic [7:0] MC_WDATA, MC_RDATA, EVENT_SET, q, s, m;
    logic [1:0] MC_SEL;
    logic MC_WR, MC_RD, MC_IRQ, SCI_STS, SCI_OUT_N, WAKE_REQ, SLEEP_ENABLE, h;
    logic [2:0] SLEEP_TYPE;
    logic [7:0] cidx [3] = '{8'h30, 8'h60, 8'h61};
    logic [7:0] cmask [3] = '{8'h01, 8'h0f, 8'hf8};
    logic [15:0] rsv [5] = '{16'h0, 16'h2, 16'h4, 16'h6, 16'h7};
    int probe [5] = '{-1, 0, 5, 7, 8};
    int errors = 0;
    int n_checks = 0;

    apm_block apm_block_i (
        .CLOCK, .RESET_N, .CFG_RESET_N, .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA,
        .IO_HIT, .IO_RDATA, .CFG_INDEX, .CFG_WR, .CFG_RD, .CFG_WDATA,
        .CFG_RDATA, .MC_SEL, .MC_WR, .MC_RD, .MC_WDATA, .MC_RDATA, .MC_IRQ,
        .CONTROLLER_SCI_STATUS(SCI_STS), .EVENT_SET, .SCI_OUT_N, .WAKE_REQ,
        .SLEEP_ENABLE, .SLEEP_TYPE
    );

    apm_mc_model apm_mc_model_i (
        .clock(CLOCK), .mc_sel(MC_SEL), .mc_wr(MC_WR), .mc_rd(MC_RD),
        .mc_wdata(MC_WDATA), .mc_rdata(MC_RDATA), .sci_status(SCI_STS)
    );

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // one host cycle; after a write q holds the controller irq of c1
    task automatic io(input logic wr, input logic [15:0] a, logic [7:0] d);
        @(negedge CLOCK);
        IO_ADDR = a;
        IO_WDATA = d;
        IO_WR = wr;
        IO_RD = !wr;
        #1 h = IO_HIT;
        @(negedge CLOCK);
        IO_WR = 1'b0;
        IO_RD = 1'b0;
        IO_WDATA = ~d;
        q = wr ? {7'h00, MC_IRQ} : IO_RDATA;
    endtask : io

    task automatic cfg(input logic wr, input logic [7:0] idx, d);
        @(negedge CLOCK);
        CFG_INDEX = idx;
        CFG_WDATA = d;
        CFG_WR = wr;
        CFG_RD = !wr;
        @(negedge CLOCK);
        CFG_WR = 1'b0;
        CFG_RD = 1'b0;
        CFG_WDATA = ~d;
        q = CFG_RDATA;
    endtask : cfg

    task automatic ev(input logic [7:0] e);
        @(negedge CLOCK);
        EVENT_SET = e;
        @(negedge CLOCK);
        EVENT_SET = 8'h00;
    endtask : ev

    function automatic logic [7:0] bit8(input logic b);
        return {7'h00, b};
    endfunction : bit8

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    initial begin : watchdog
        #200000;
        errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        {RESET_N, CFG_RESET_N, IO_WR, IO_RD, CFG_WR, CFG_RD} = 6'h00;
        IO_ADDR = 16'h0000;
        base = 16'h0ff8;
        IO_WDATA = 8'h00;
        CFG_INDEX = 8'h00;
        CFG_WDATA = 8'h00;
        EVENT_SET = 8'h00;
        repeat (10) @(negedge CLOCK);
        RESET_N = 1'b1;
        CFG_RESET_N = 1'b1;
        void'($urandom(13170));
        foreach (cidx[i]) begin
            cfg(1'b0, cidx[i], 8'h00);
            check("cfg reset", q, 8'h00);
            cfg(1'b1, cidx[i], 8'hff);
            cfg(1'b0, cidx[i], 8'h00);
            check("cfg mask", q, cmask[i]);
        end
        cfg(1'b1, 8'h30, 8'h00);
        io(1'b0, base + 16'h1, 8'h00);
        check("hit inactive", bit8(h), 8'h00);
        check("read inactive", q, 8'h00);
        $display("test reset and config done");

        repeat (6) begin
            base = {4'h0, 9'($urandom), 3'h0};
            cfg(1'b1, 8'h60, base[15:8]);
            cfg(1'b1, 8'h61, base[7:0]);
            cfg(1'b1, 8'h30, 8'h01);
            foreach (probe[k]) begin
                io(1'b0, 16'(int'(base) + probe[k]), 8'h00);
                check("io hit", bit8(h), bit8(probe[k] inside {[0:7]}));
            end
            s = 8'($urandom);
            m = 8'($urandom);
            apm_mc_model_i.put(`APM_MC_STATUS, s);
            io(1'b0, base + 16'h1, 8'h00);
            check("status", q, s & 8'h8f);
            io(1'b1, base + 16'h1, 8'h00);
            check("irq status", q, 8'h01);
            io(1'b1, base + 16'h1, m);
            io(1'b0, base + 16'h1, 8'h00);
            check("status clear", q, s & ~m & 8'h8f);
            io(1'b1, base + 16'h3, s);
            check("irq enable", q, 8'h01);
            apm_mc_model_i.put(`APM_MC_ENABLE, ~s);
            apm_mc_model_i.get(`APM_MC_ENABLE, q);
            check("mc enable", q, s & 8'h07);
            io(1'b1, base + 16'h5, m);
            check("irq control", q, 8'h01);
            apm_mc_model_i.put(`APM_MC_CONTROL, 8'hff);
            io(1'b0, base + 16'h5, 8'h00);
            check("control", q, (m & 8'h3e) | 8'h20);
            check("sleep type", {5'h00, SLEEP_TYPE}, {5'h00, m[4:2]});
            check("sleep enable", bit8(SLEEP_ENABLE), 8'h01);
            foreach (rsv[k]) begin
                io(1'b1, base + rsv[k], 8'hff);
                check("irq reserved", q, 8'h00);
                io(1'b0, base + rsv[k], 8'h00);
                check("reserved", q, 8'h00);
            end
        end
        $display("test decode and registers done");

        io(1'b1, base + 16'h5, 8'h00);
        for (int i = 0; i < 3; i++) begin
            io(1'b1, base + 16'h3, 8'h00);
            ev(8'(1 << i));
            check("sci masked", bit8(SCI_OUT_N), 8'h01);
            io(1'b1, base + 16'h3, 8'(1 << i));
            check("sci enabled", bit8(SCI_OUT_N), 8'h00);
            check("wake", bit8(WAKE_REQ), bit8(i == 2));
            apm_mc_model_i.put(`APM_MC_STATUS, 8'h88);
            check("sci other", bit8(SCI_OUT_N), 8'h01);
        end
        io(1'b1, base + 16'h5, 8'h02);
        check("sci override", bit8(SCI_OUT_N), 8'h00);
        io(1'b1, base + 16'h1, 8'hff);
        check("sci cleared", bit8(SCI_OUT_N), 8'h01);
        apm_mc_model_i.sci(1'b1);
        check("sci controller", bit8(SCI_OUT_N), 8'h00);
        apm_mc_model_i.sci(1'b0);
        $display("test interrupt pin done");

        apm_mc_model_i.put(`APM_MC_STATUS, 8'h81);
        @(negedge CLOCK);
        CFG_RESET_N = 1'b0;
        @(negedge CLOCK);
        CFG_RESET_N = 1'b1;
        io(1'b0, base + 16'h1, 8'h00);
        check("hit after cfg reset", bit8(h), 8'h00);
        cfg(1'b0, 8'h61, 8'h00);
        check("base after cfg reset", q, 8'h00);
        apm_mc_model_i.get(`APM_MC_STATUS, q);
        check("status kept", q, 8'h81);
        $display("test config reset done");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
